// >>> hdl/retimer_channel_regs.v
// per-channel control and status register bank of a four-channel retimer
//
// Contract
// - channel select value steers later accesses until rewritten
// - only the select register decodes at the select address
// - four independent channel register copies, one per channel
// - control bit 3 resets that channel's core state machine; zero normal
// - control bit 2 restores that channel's registers to defaults
// - control bit 1 resets that channel's reference clock domain
// - control bit 0 resets that channel's oscillator divider domain
// - lock-loss flag set on lock lost after acquired; clears on read
// - signal-loss flag set only after signal detected then lost
// - status bit 7 high while data rate within ppm tolerance
// - status bit 6 high once equalizer adaptation has finished
// - status bit 5 high when signal insufficient for lock
// - status bits 4 and 3 both show recovery lock
// - status bit 2 high when enough transitions seen for lock
// - status bit 1 high when rate exceeds oscillator upper limit
// - register 3 holds software forced boost stages, default zero
// - broadcast bit makes writes reach all channels; reads use index
// - channel set reachable only while enable bit set
`timescale 1ns/10ps
`include "retimer_channel_map.vh"

module retimer_channel_regs #(
   parameter NCH = `NUM_CHANNELS
) (
   input  wire             CLK,
   input  wire             RST_N,
   input  wire             WR_EN,
   input  wire             RD_EN,
   input  wire [7:0]       ADDR,
   input  wire [7:0]       WR_DATA,
   output reg  [7:0]       RD_DATA,
   output reg              RD_VALID,
   output wire             SHARED_SEL,
   input  wire [NCH-1:0]   LOCK_IN,
   input  wire [NCH-1:0]   SIGNAL_DETECT_IN,
   input  wire [NCH-1:0]   PPM_OK_IN,
   input  wire [NCH-1:0]   ADAPT_DONE_IN,
   input  wire [NCH-1:0]   FAIL_LOCK_IN,
   input  wire [NCH-1:0]   TRANS_MET_IN,
   input  wire [NCH-1:0]   RATE_HIGH_IN,
   output reg  [NCH-1:0]   CORE_RESET,
   output reg  [NCH-1:0]   REFERENCE_DOMAIN_RESET,
   output reg  [NCH-1:0]   OSCILLATOR_DIVIDER_RESET,
   output reg  [8*NCH-1:0] FORCED_BOOST
);

   // ----------------------------------------
   // input synchronisers, three stages
   // ----------------------------------------
   localparam NSTAT = 7;
   wire [NSTAT*NCH-1:0] raw_status;
   reg  [NSTAT*NCH-1:0] sync_a;
   reg  [NSTAT*NCH-1:0] sync_b;
   reg  [NSTAT*NCH-1:0] sync_c;
   reg  [NSTAT*NCH-1:0] stable;

   assign raw_status = {RATE_HIGH_IN, TRANS_MET_IN, FAIL_LOCK_IN, ADAPT_DONE_IN,
                        PPM_OK_IN, SIGNAL_DETECT_IN, LOCK_IN};

   // a change counts only once stages two and three agree
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync_a <= {NSTAT*NCH{1'b0}};
         sync_b <= {NSTAT*NCH{1'b0}};
         sync_c <= {NSTAT*NCH{1'b0}};
         stable <= {NSTAT*NCH{1'b0}};
      end else begin
         sync_a <= raw_status;
         sync_b <= sync_a;
         sync_c <= sync_b;
         stable <= (sync_b & sync_c) | (stable & (sync_b | sync_c));
      end
   end

   wire [NCH-1:0] lock_s      = stable[0*NCH +: NCH];
   wire [NCH-1:0] sigdet_s    = stable[1*NCH +: NCH];
   wire [NCH-1:0] ppm_s       = stable[2*NCH +: NCH];
   wire [NCH-1:0] adapt_s     = stable[3*NCH +: NCH];
   wire [NCH-1:0] faillock_s  = stable[4*NCH +: NCH];
   wire [NCH-1:0] trans_s     = stable[5*NCH +: NCH];
   wire [NCH-1:0] ratehigh_s  = stable[6*NCH +: NCH];

   // ----------------------------------------
   // channel select register
   // ----------------------------------------
   reg  [3:0] select;
   wire       sel_hit     = (ADDR == `ADDR_SELECT);
   wire       chan_enable = select[`SEL_ENABLE_BIT];
   wire       broadcast   = select[`SEL_BROADCAST_BIT];
   wire [1:0] target      = select[`SEL_INDEX_HI:`SEL_INDEX_LO];

   // the select register is the only decode at its address
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         select <= `SELECT_RESET;
      else if (WR_EN && sel_hit)
         select <= WR_DATA[3:0]; // held until the next write here
   end

   // with the enable clear, accesses belong to the shared set outside
   assign SHARED_SEL = !chan_enable || sel_hit;

   wire chan_wr = WR_EN && chan_enable && !sel_hit;
   wire chan_rd = RD_EN && chan_enable && !sel_hit;

   // ----------------------------------------
   // per-channel register copies
   // ----------------------------------------
   reg [3:0]     rst_ctl  [0:NCH-1]; // one copy per channel
   reg [NCH-1:0] lock_seen;
   reg [NCH-1:0] sig_seen;
   reg [NCH-1:0] lock_lost;
   reg [NCH-1:0] sig_lost;
   reg [NCH-1:0] regs_rst;
   reg [NCH-1:0] clr_flags;
   integer       k_dec;
   integer       k_ctl;
   integer       k_bst;
   integer       k_flg;
   integer       k_out;

   // true when a channel write in this cycle reaches channel ch
   function wr_hits;
      input integer ch;
      begin
         wr_hits = chan_wr && (broadcast || (target == ch[1:0]));
      end
   endfunction

   function [7:0] status_byte;
      input integer ch;
      begin
         status_byte = `ZERO_BYTE;
         status_byte[`ST_PPM_BIT]       = ppm_s[ch];
         status_byte[`ST_ADAPT_BIT]     = adapt_s[ch];
         status_byte[`ST_FAIL_LOCK_BIT] = faillock_s[ch];
         status_byte[`ST_LOCK_BIT]      = lock_s[ch];
         status_byte[`ST_CDR_LOCK_BIT]  = lock_s[ch];
         status_byte[`ST_TRANS_BIT]     = trans_s[ch];
         status_byte[`ST_RATE_HIGH_BIT] = ratehigh_s[ch];
      end
   endfunction

   // one process per register kind keeps every variable on a single driver
   always @* begin
      regs_rst  = {NCH{1'b0}};
      clr_flags = {NCH{1'b0}};
      for (k_dec = 0; k_dec < NCH; k_dec = k_dec + 1) begin
         // the register-reset bit holds its copy at defaults while set;
         // its own byte stays writable so software can release it
         regs_rst[k_dec]  = rst_ctl[k_dec][`RST_REGS_BIT];
         clr_flags[k_dec] = chan_rd && (target == k_dec[1:0]) &&
                            (ADDR == `ADDR_LOSS_FLAGS);
      end
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (k_ctl = 0; k_ctl < NCH; k_ctl = k_ctl + 1)
            rst_ctl[k_ctl] <= `CONTROL_RESET;
      end else begin
         for (k_ctl = 0; k_ctl < NCH; k_ctl = k_ctl + 1) begin
            if (wr_hits(k_ctl) && ADDR == `ADDR_RESET_CONTROL) begin
               // bits stay until software writes zero back, except that bit 2 clears bits 3, 1 and 0
               rst_ctl[k_ctl] <= WR_DATA[3:0];
            end else if (regs_rst[k_ctl]) begin
               rst_ctl[k_ctl][`RST_CORE_BIT]   <= 1'b0;
               rst_ctl[k_ctl][`RST_REFDOM_BIT] <= 1'b0;
               rst_ctl[k_ctl][`RST_OSCDIV_BIT] <= 1'b0;
            end
         end
      end
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         FORCED_BOOST <= {NCH{`BOOST_RESET}};
      end else begin
         for (k_bst = 0; k_bst < NCH; k_bst = k_bst + 1) begin
            if (regs_rst[k_bst])
               FORCED_BOOST[8*k_bst +: 8] <= `BOOST_RESET;
            else if (wr_hits(k_bst) && ADDR == `ADDR_FORCED_BOOST)
               FORCED_BOOST[8*k_bst +: 8] <= WR_DATA;
         end
      end
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         lock_seen <= {NCH{1'b0}};
         sig_seen  <= {NCH{1'b0}};
         lock_lost <= {NCH{1'b0}};
         sig_lost  <= {NCH{1'b0}};
      end else begin
         for (k_flg = 0; k_flg < NCH; k_flg = k_flg + 1) begin
            if (regs_rst[k_flg]) begin
               lock_seen[k_flg] <= 1'b0;
               sig_seen[k_flg]  <= 1'b0;
               lock_lost[k_flg] <= 1'b0;
               sig_lost[k_flg]  <= 1'b0;
            end else begin
               // arm on acquisition, disarm on loss; a set beats a read clear
               lock_seen[k_flg] <= lock_s[k_flg];
               sig_seen[k_flg]  <= sigdet_s[k_flg];
               if (lock_seen[k_flg] && !lock_s[k_flg])
                  lock_lost[k_flg] <= 1'b1;
               else if (clr_flags[k_flg])
                  lock_lost[k_flg] <= 1'b0;
               if (sig_seen[k_flg] && !sigdet_s[k_flg])
                  sig_lost[k_flg] <= 1'b1;
               else if (clr_flags[k_flg])
                  sig_lost[k_flg] <= 1'b0;
            end
         end
      end
   end

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         CORE_RESET               <= {NCH{1'b0}};
         REFERENCE_DOMAIN_RESET   <= {NCH{1'b0}};
         OSCILLATOR_DIVIDER_RESET <= {NCH{1'b0}};
      end else begin
         for (k_out = 0; k_out < NCH; k_out = k_out + 1) begin
            CORE_RESET[k_out]               <= rst_ctl[k_out][`RST_CORE_BIT];
            REFERENCE_DOMAIN_RESET[k_out]   <= rst_ctl[k_out][`RST_REFDOM_BIT];
            OSCILLATOR_DIVIDER_RESET[k_out] <= rst_ctl[k_out][`RST_OSCDIV_BIT];
         end
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // reads always use the index, never the broadcast bit
   reg [7:0] next_rd_data;
   always @* begin
      next_rd_data = `ZERO_BYTE;
      case (ADDR)
         `ADDR_RESET_CONTROL: next_rd_data = {4'h0, rst_ctl[target]};
         `ADDR_LOSS_FLAGS: begin
            next_rd_data[`LOCK_LOSS_BIT]   = lock_lost[target];
            next_rd_data[`SIGNAL_LOSS_BIT] = sig_lost[target];
         end
         `ADDR_RECOVERY_STATUS: next_rd_data = status_byte(target);
         `ADDR_FORCED_BOOST: next_rd_data = FORCED_BOOST[8*target +: 8];
         default: next_rd_data = `ZERO_BYTE;
      endcase
   end

   // select register reads are not answered: RD_VALID stays low and RD_DATA holds
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         RD_DATA  <= `ZERO_BYTE;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= chan_rd;
         if (chan_rd)
            RD_DATA <= next_rd_data;
      end
   end

endmodule // retimer_channel_regs

// >>> hdl/retimer_channel_map.vh
// register map and field constants for the retimer channel register bank
`ifndef RETIMER_CHANNEL_MAP_VH
`define RETIMER_CHANNEL_MAP_VH
`define ADDR_SELECT          8'hFF
`define ADDR_RESET_CONTROL   8'h00
`define ADDR_LOSS_FLAGS      8'h01
`define ADDR_RECOVERY_STATUS 8'h02
`define ADDR_FORCED_BOOST    8'h03
`define SEL_BROADCAST_BIT    3
`define SEL_ENABLE_BIT       2
`define SEL_INDEX_HI         1
`define SEL_INDEX_LO         0
`define RST_CORE_BIT         3
`define RST_REGS_BIT         2
`define RST_REFDOM_BIT       1
`define RST_OSCDIV_BIT       0
`define LOCK_LOSS_BIT        4
`define SIGNAL_LOSS_BIT      0
`define ST_PPM_BIT           7
`define ST_ADAPT_BIT         6
`define ST_FAIL_LOCK_BIT     5
`define ST_LOCK_BIT          4
`define ST_CDR_LOCK_BIT      3
`define ST_TRANS_BIT         2
`define ST_RATE_HIGH_BIT     1
`define SELECT_RESET         4'h0
`define CONTROL_RESET        4'h0
`define BOOST_RESET          8'h00
`define ZERO_BYTE            8'h00
`define NUM_CHANNELS         4
`endif

// >>> verification/retimer_channel_regs_monitor.sv
// assertion checker for the retimer channel register bank
`timescale 1ns/10ps
module retimer_channel_regs_monitor #(
   parameter NCH = 4
) (
   input wire             CLK,
   input wire             RST_N,
   input wire             WR_EN,
   input wire             RD_EN,
   input wire [7:0]       ADDR,
   input wire [7:0]       WR_DATA,
   input wire [7:0]       RD_DATA,
   input wire             RD_VALID,
   input wire             SHARED_SEL,
   input wire [NCH-1:0]   CORE_RESET,
   input wire [NCH-1:0]   REFERENCE_DOMAIN_RESET,
   input wire [NCH-1:0]   OSCILLATOR_DIVIDER_RESET,
   input wire [8*NCH-1:0] FORCED_BOOST
);
   // ------------------------------------------------------------
   // port relations
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // register-reset writes clear the other bits again one cycle after the write, so they are left out
   sequence s_ctl_wr(b);
      WR_EN && !SHARED_SEL && ADDR == 8'h00 && !WR_DATA[2] && b;
   endsequence
   chk_read_answered: assert property ((RD_EN && !SHARED_SEL) |=> RD_VALID)
      else $error("channel read not answered");
   chk_shared_silent: assert property ((RD_EN && SHARED_SEL) |=> !RD_VALID)
      else $error("shared read answered");
   chk_select_shared: assert property (ADDR == 8'hFF |-> SHARED_SEL)
      else $error("select address decoded as channel");
   chk_lock_pair: assert property (RD_VALID && $past(ADDR) == 8'h02 |-> RD_DATA[4] == RD_DATA[3])
      else $error("lock bits differ");
   chk_data_holds: assert property (!RD_VALID |-> $stable(RD_DATA))
      else $error("read data moved without a read");
   chk_ctl_cause: assert property ($changed({CORE_RESET, REFERENCE_DOMAIN_RESET,
      OSCILLATOR_DIVIDER_RESET}) |-> $past(WR_EN) || $past(WR_EN, 2))
      else $error("reset outputs moved without a write");
   chk_boost_cause: assert property ($changed(FORCED_BOOST) |-> $past(WR_EN) || $past(WR_EN, 2))
      else $error("boost moved without a write");
   chk_core_set: assert property (s_ctl_wr(WR_DATA[3]) |-> ##[1:2] (|CORE_RESET))
      else $error("core reset not raised");
   chk_ref_set: assert property (s_ctl_wr(WR_DATA[1]) |-> ##[1:2] (|REFERENCE_DOMAIN_RESET))
      else $error("reference reset not raised");
   chk_osc_set: assert property (s_ctl_wr(WR_DATA[0]) |-> ##[1:2] (|OSCILLATOR_DIVIDER_RESET))
      else $error("divider reset not raised");
endmodule // retimer_channel_regs_monitor
bind retimer_channel_regs retimer_channel_regs_monitor #(.NCH(NCH)) u_mon (
   .CLK(CLK), .RST_N(RST_N), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(ADDR),
   .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .SHARED_SEL(SHARED_SEL),
   .CORE_RESET(CORE_RESET), .REFERENCE_DOMAIN_RESET(REFERENCE_DOMAIN_RESET),
   .OSCILLATOR_DIVIDER_RESET(OSCILLATOR_DIVIDER_RESET), .FORCED_BOOST(FORCED_BOOST));

// >>> verification/smbus_host_model.sv
// management host model driving the byte-wide register port
`timescale 1ns/10ps
module smbus_host_model (
   input  wire       CLK,
   input  wire       RD_VALID,
   input  wire [7:0] RD_DATA,
   output reg        WR_EN = 1'b0,
   output reg        RD_EN = 1'b0,
   output reg  [7:0] ADDR = 8'h00,
   output reg  [7:0] WR_DATA = 8'h00
);
   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   // idle lines show the inverse of the last value, never a stale match
   task wr(input [7:0] a, input [7:0] d);
      @(posedge CLK);
      WR_EN <= 1'b1;
      ADDR <= a;
      WR_DATA <= d;
      @(posedge CLK);
      WR_EN <= 1'b0;
      ADDR <= ~a;
      WR_DATA <= ~d;
   endtask
   task rd(input [7:0] a, output [7:0] d, output v);
      @(posedge CLK);
      RD_EN <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD_EN <= 1'b0;
      ADDR <= ~a;
      // taken at the edge where the answer stands, before it is replaced
      @(posedge CLK);
      v = RD_VALID;
      d = RD_DATA;
   endtask
   task ctl_release;
      wr(8'h00, 8'h00);
   endtask
endmodule // smbus_host_model

// >>> verification/retimer_channel_regs_tb.sv
// self-checking testbench for the retimer channel register bank
`timescale 1ns/10ps
module retimer_channel_regs_tb;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [3:0]  lock = 0, sig = 0, ppm = 0, adapt = 0, fail = 0, trans = 0, rate = 0;
   wire        wr_en, rd_en, rd_valid, shared_sel;
   wire [7:0]  addr, wr_data, rd_data;
   wire [3:0]  core_rst, ref_rst, osc_rst;
   wire [31:0] boost;
   reg  [7:0]  d;
   reg         v;
   reg  [5:0]  p;
   integer     failures = 0, n_checks = 0, c;
   always #5 clk = ~clk;
   smbus_host_model h (.CLK(clk), .RD_VALID(rd_valid), .RD_DATA(rd_data), .WR_EN(wr_en),
      .RD_EN(rd_en), .ADDR(addr), .WR_DATA(wr_data));
   retimer_channel_regs dut (.CLK(clk), .RST_N(rst_n), .WR_EN(wr_en), .RD_EN(rd_en),
      .ADDR(addr), .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .SHARED_SEL(shared_sel), .LOCK_IN(lock), .SIGNAL_DETECT_IN(sig), .PPM_OK_IN(ppm),
      .ADAPT_DONE_IN(adapt), .FAIL_LOCK_IN(fail), .TRANS_MET_IN(trans), .RATE_HIGH_IN(rate),
      .CORE_RESET(core_rst), .REFERENCE_DOMAIN_RESET(ref_rst),
      .OSCILLATOR_DIVIDER_RESET(osc_rst), .FORCED_BOOST(boost));
   // ------------------------------------------------------------
   // checking and scenarios
   // ------------------------------------------------------------
   task chk(input string nm, input [31:0] s, input [31:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task print_verdict;
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task t_defaults;
      h.rd(8'h02, d, v);
      chk("shared read", v, 0);
      h.wr(8'hFF, 8'h04);
      h.rd(8'h03, d, v);
      chk("boost default", {v, d}, 9'h100);
      h.rd(8'h00, d, v);
      chk("control default", {v, d}, 9'h100);
      h.rd(8'hFF, d, v);
      chk("select read", v, 0);
   endtask
   task t_copies;
      for (c = 0; c < 4; c++) begin
         h.wr(8'hFF, 8'h04 | c);
         h.wr(8'h03, 8'h11 * (c + 1));
      end
      for (c = 0; c < 4; c++) begin
         h.wr(8'hFF, 8'h04 | c);
         h.rd(8'h03, d, v);
         chk("boost copy", d, 8'h11 * (c + 1));
      end
      chk("boost pins", boost, 32'h4433_2211);
   endtask
   task t_broadcast;
      h.wr(8'hFF, 8'h0E);
      h.wr(8'h03, 8'hA5);
      repeat (3) @(posedge clk);
      chk("broadcast pins", boost, 32'hA5A5_A5A5);
      h.wr(8'hFF, 8'h06);
      h.wr(8'h03, 8'h5A);
      h.wr(8'hFF, 8'h0E);
      h.rd(8'h03, d, v);
      chk("broadcast read", d, 8'h5A);
   endtask
   task t_controls;
      h.wr(8'h00, 8'h0B);
      repeat (3) @(posedge clk);
      chk("reset pins", {core_rst, ref_rst, osc_rst}, 12'hFFF);
      h.ctl_release;
      repeat (3) @(posedge clk);
      chk("reset release", {core_rst, ref_rst, osc_rst}, 12'h000);
      h.wr(8'hFF, 8'h05);
      h.wr(8'h00, 8'h04);
      repeat (3) @(posedge clk);
      chk("register reset", boost[15:8], 8'h00);
      h.ctl_release;
      h.rd(8'h03, d, v);
      chk("defaults kept", d, 8'h00);
   endtask
   task t_flags;
      h.wr(8'hFF, 8'h07);
      lock[3] <= 1'b1;
      sig[3] <= 1'b1;
      repeat (8) @(posedge clk);
      lock[3] <= 1'b0;
      sig[3] <= 1'b0;
      repeat (8) @(posedge clk);
      h.rd(8'h01, d, v);
      chk("loss flags", d, 8'h11);
      h.rd(8'h01, d, v);
      chk("clear on read", d[4], 0);
      h.wr(8'hFF, 8'h04);
      h.rd(8'h01, d, v);
      chk("no signal seen", d[0], 0);
   endtask
   task t_status;
      h.wr(8'hFF, 8'h05);
      for (c = 0; c < 6; c++) begin
         p = 6'h01 << c;
         {ppm[1], adapt[1], fail[1], lock[1], trans[1], rate[1]} <= p;
         repeat (8) @(posedge clk);
         h.rd(8'h02, d, v);
         chk("status", d[7:1], {p[5:2], p[2:0]});
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_defaults;
      t_copies;
      t_broadcast;
      t_controls;
      t_flags;
      t_status;
      print_verdict;
   end
   // the whole sequence needs well under 1000 cycles
   initial begin
      #100000;
      failures++;
      print_verdict;
   end
endmodule // retimer_channel_regs_tb
